// ### dv/cfg_host_model.sv
// Host model issuing configuration requests on the register port
module cfg_host_model (
  input wire logic clk_i,
  output logic [sriov_cap_pkg::ADDR_W-1:0] addr_o,
  output logic [2:0] func_sel_o,
  output logic [sriov_cap_pkg::DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import sriov_cap_pkg::*;
  initial begin
    addr_o = 8'hFF;
    func_sel_o = 3'h7;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Released lines carry the inverse so a stale value never looks valid
  task automatic issue(input logic [7:0] a, input logic [2:0] f,
                       input logic [31:0] d, input logic w);
    @(posedge clk_i);
    addr_o <= a;
    func_sel_o <= f;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    func_sel_o <= ~f;
    wdata_o <= ~d;
    #1;
  endtask
endmodule

// ### dv/sriov_cap_monitor.sv
// Assertion checker for the capability register bank
module sriov_cap_monitor #(
  parameter bit virtualization_feature_on = 1'b1,
  parameter bit alt_routing_id_feature_on = 1'b1,
  parameter logic [11:0] next_capability_pointer = 12'h000,
  parameter logic [3:0] capability_version = 4'h1,
  parameter logic [15:0] initial_virtual_function_count = 16'h0006,
  parameter logic [15:0] total_virtual_function_count = 16'h0006,
  parameter logic [2:0] first_bar_type_select = 3'h4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [sriov_cap_pkg::ADDR_W-1:0] addr_i,
  input wire logic [2:0] func_sel_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [sriov_cap_pkg::DATA_W-1:0] rdata_o,
  input wire logic cap_present_o,
  input wire logic config_invalid_o,
  input wire logic bar0_enabled_o,
  input wire logic bar0_is_io_o,
  input wire logic bar0_prefetch_o,
  input wire logic bar0_is_64_o,
  input wire logic bar1_upper_half_o,
  input wire logic bar0_reserved_o,
  input wire logic write_refused_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import sriov_cap_pkg::*;
  localparam bit PRES = virtualization_feature_on && alt_routing_id_feature_on;
  localparam bit BAD =
    (virtualization_feature_on && !alt_routing_id_feature_on) ||
    (total_virtual_function_count != initial_virtual_function_count);
  localparam logic [2:0] BT = first_bar_type_select;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd(logic [7:0] a);
    rd_i && addr_i == a && func_sel_i == 3'h0 && cap_present_o;
  endsequence
  property p_present; cap_present_o == PRES; endproperty
  a_present: assert property (p_present) else $error("presence wrong");
  property p_other;
    rd_i && func_sel_i != 3'h0 |=> rdata_o == 32'h0;
  endproperty
  a_other: assert property (p_other) else $error("other function read");
  property p_absent;
    rd_i && !cap_present_o && addr_i <= OFF_BAR0 |=> rdata_o == 32'h0;
  endproperty
  a_absent: assert property (p_absent) else $error("hidden field read");
  property p_header;
    s_rd(OFF_HEADER) |=> rdata_o ==
      {next_capability_pointer, capability_version, CAP_ID};
  endproperty
  a_header: assert property (p_header) else $error("header wrong");
  property p_counts;
    s_rd(OFF_VF_COUNTS) |=> rdata_o ==
      {total_virtual_function_count, initial_virtual_function_count};
  endproperty
  a_counts: assert property (p_counts) else $error("counts wrong");
  // Flags settle one edge after release, so the first edge is skipped
  property p_bar32;
    $past(rst_n_i) |-> bar0_is_io_o == (PRES && BT == BAR_IO32)
      && bar0_reserved_o == (BT[2:1] == 2'b01) && bar0_enabled_o ==
      (PRES && BT != BAR_DISABLED && BT[2:1] != 2'b01);
  endproperty
  a_bar32: assert property (p_bar32) else $error("bar decode wrong");
  property p_bar64;
    $past(rst_n_i) |-> bar0_is_64_o == (PRES && BT[2:1] == 2'b11)
      && bar1_upper_half_o == bar0_is_64_o
      && bar0_prefetch_o ==
      (PRES && (BT == BAR_MEM32_PF || BT == BAR_MEM64_PF));
  endproperty
  a_bar64: assert property (p_bar64) else $error("bar pair wrong");
  property p_invalid; $past(rst_n_i) |-> config_invalid_o == BAD; endproperty
  a_invalid: assert property (p_invalid) else $error("invalid");
  property p_refuse;
    // Only aligned offsets name a field; others are unmapped and ignored
    wr_i && func_sel_i == 3'h0 && addr_i <= OFF_BAR0 &&
      addr_i[1:0] == 2'b00 && cap_present_o |=> write_refused_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write kept");
  c_header: cover property (s_rd(OFF_HEADER));
  c_refuse: cover property (wr_i && cap_present_o ##1 write_refused_o);
  c_bar64: cover property (bar0_is_64_o);
endmodule
bind sriov_capability_config sriov_cap_monitor #(
  .virtualization_feature_on(virtualization_feature_on),
  .alt_routing_id_feature_on(alt_routing_id_feature_on),
  .next_capability_pointer(next_capability_pointer),
  .capability_version(capability_version),
  .initial_virtual_function_count(initial_virtual_function_count),
  .total_virtual_function_count(total_virtual_function_count),
  .first_bar_type_select(first_bar_type_select)
) i_monitor (
  .clk_i, .rst_n_i, .addr_i, .func_sel_i, .wr_i, .rd_i, .rdata_o,
  .cap_present_o, .config_invalid_o, .bar0_enabled_o, .bar0_is_io_o,
  .bar0_prefetch_o, .bar0_is_64_o, .bar1_upper_half_o, .bar0_reserved_o,
  .write_refused_o);

// ### dv/testbench.sv
// Testbench for the capability register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sriov_cap_pkg::*;
  localparam int NI = 12;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  wire logic [7:0] addr;
  wire logic [2:0] fsel;
  wire logic [31:0] wdata;
  wire logic wr, rd;
  logic [31:0] rdata [NI];
  logic [NI-1:0] pres_o, inv_o, en_o, io_o, pf_o, b64_o, up_o, rsv_o, ref_o;
  int err_count = 0;
  int check_count = 0;
  logic exp_refused = 1'b0;
  always #25 clk_i = ~clk_i;
  cfg_host_model i_host (.clk_i, .addr_o(addr), .func_sel_o(fsel),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  // Instances 0 to 7 take each BAR0 code; 8 to 11 take odd setups
  for (genvar k = 0; k < NI; k++) begin : g_cfg
    sriov_capability_config #(
      .virtualization_feature_on(k != 8),
      .alt_routing_id_feature_on(k != 9),
      .next_capability_pointer(12'hABC),
      .capability_version(4'h2),
      .initial_virtual_function_count(16'h0005),
      .total_virtual_function_count((k == 10) ? 16'h0007 : 16'h0005),
      .function_dependency_link(16'h0001),
      .virtual_function_layout_mode(layout_mode_t'(k == 11)),
      .first_offset_override(k == 10),
      .first_virtual_function_offset(16'h0070 + 16'(k)),
      .virtual_function_device_code(16'h5A5A),
      .supported_page_size_bitmap((k == 11) ? 32'h0 : 32'h8000_0A50),
      .first_bar_type_select((k < 8) ? 3'(k) : 3'h4)
    ) i_sriov_capability_config (
      .clk_i, .rst_n_i, .addr_i(addr), .func_sel_i(fsel), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata[k]), .cap_present_o(pres_o[k]),
      .config_invalid_o(inv_o[k]), .bar0_enabled_o(en_o[k]),
      .bar0_is_io_o(io_o[k]), .bar0_prefetch_o(pf_o[k]),
      .bar0_is_64_o(b64_o[k]), .bar1_upper_half_o(up_o[k]),
      .bar0_reserved_o(rsv_o[k]), .write_refused_o(ref_o[k]));
  end
  function automatic logic [2:0] bar_of(int k);
    return (k < 8) ? 3'(k) : BAR_MEM32_NP;
  endfunction
  function automatic logic pres(int k);
    return k != 8 && k != 9;
  endfunction
  function automatic logic [15:0] tot(int k);
    return (k == 10) ? 16'h0007 : 16'h0005;
  endfunction
  function automatic logic [31:0] exp_word(int k, logic [7:0] a,
                                           logic [2:0] f);
    logic [2:0] b;
    logic [31:0] w;
    b = bar_of(k);
    case (a)
      OFF_HEADER: w = {12'hABC, 4'h2, CAP_ID};
      OFF_VF_COUNTS: w = {tot(k), 16'h0005};
      OFF_OFFSET_DEP: w = {16'h0001, (k == 11) ? 16'h003F :
        (k == 10) ? 16'h007A : 16'h0040};
      OFF_VF_DEVICE: w = {16'h5A5A, 16'h0000};
      OFF_PAGE_SIZES: w = (k == 11) ? 32'h0 : 32'h8000_0A50;
      OFF_PAGE_INFO: w = (k == 11) ? 32'h0 : 32'h0000_0010;
      OFF_BAR0: w = {28'h0, (b == BAR_IO32) ? 4'h1 : (b == BAR_MEM32_PF) ?
        4'h8 : (b == BAR_MEM64_NP) ? 4'h4 : (b == BAR_MEM64_PF) ? 4'hC : 4'h0};
      OFF_STATUS: w = {27'h0, exp_refused && pres(k), b[2:1] == 2'b01,
        tot(k) != 16'h0005, k == 9, pres(k)};
      default: w = 32'h0;
    endcase
    if (f != 3'h0 || (!pres(k) && a != OFF_STATUS)) begin
      w = 32'h0;
    end
    return w;
  endfunction
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_all(input logic [7:0] a, input logic [2:0] f);
    i_host.issue(a, f, 32'h0, 1'b0);
    for (int k = 0; k < NI; k++) begin
      cmp32(rdata[k], exp_word(k, a, f));
    end
    // Read data stand one cycle only, so the next cycle must show zero
    @(posedge clk_i);
    #1;
    for (int k = 0; k < NI; k++) begin
      cmp32(rdata[k], 32'h0);
    end
  endtask
  task automatic check_flags();
    logic [2:0] b;
    for (int k = 0; k < NI; k++) begin
      b = bar_of(k);
      cmp1(pres_o[k], pres(k));
      cmp1(inv_o[k], k == 9 || k == 10);
      cmp1(en_o[k], pres(k) && b != 3'h0 && b[2:1] != 2'b01);
      cmp1(io_o[k], b == BAR_IO32);
      cmp1(rsv_o[k], b[2:1] == 2'b01);
      cmp1(pf_o[k], b == BAR_MEM32_PF || b == BAR_MEM64_PF);
      cmp1(b64_o[k], b[2:1] == 2'b11);
      cmp1(up_o[k], b[2:1] == 2'b11);
      cmp1(ref_o[k], exp_refused && pres(k));
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // The BAR0 word is settled from the first edge after release
    repeat (2) @(posedge clk_i);
    #1;
    check_flags();
    $display("Test flags done");
    check_all(OFF_HEADER, 3'h0);
    check_all(OFF_VF_COUNTS, 3'h0);
    check_all(OFF_OFFSET_DEP, 3'h0);
    check_all(OFF_VF_DEVICE, 3'h0);
    check_all(OFF_PAGE_SIZES, 3'h0);
    check_all(OFF_PAGE_INFO, 3'h0);
    check_all(OFF_BAR0, 3'h0);
    check_all(OFF_STATUS, 3'h0);
    check_all(OFF_HEADER, 3'h1);
    check_all(8'h20, 3'h0);
    $display("Test reads done");
    for (int i = 0; i < 6; i++) begin
      i_host.issue(8'(4 * i), 3'h0, 32'hFFFF_FFFF, 1'b1);
      exp_refused = 1'b1;
      check_all(8'(4 * i), 3'h0);
    end
    check_flags();
    check_all(OFF_STATUS, 3'h0);
    i_host.issue(OFF_STATUS, 3'h0, 32'h0000_0010, 1'b1);
    exp_refused = 1'b0;
    check_flags();
    i_host.issue(OFF_HEADER, 3'h2, 32'hFFFF_FFFF, 1'b1);
    check_flags();
    $display("Test writes done");
    stop_test();
  end
endmodule

// ### hw/sriov_cap_pkg.sv
// Constants and types for the virtualization capability register bank
package sriov_cap_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Byte offsets inside the capability window
  localparam logic [7:0] OFF_HEADER = 8'h00;
  localparam logic [7:0] OFF_VF_COUNTS = 8'h04;
  localparam logic [7:0] OFF_OFFSET_DEP = 8'h08;
  localparam logic [7:0] OFF_VF_DEVICE = 8'h0C;
  localparam logic [7:0] OFF_PAGE_SIZES = 8'h10;
  localparam logic [7:0] OFF_BAR0 = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_PAGE_INFO = 8'h1C;

  // Header field positions
  localparam int HDR_NEXT_LSB = 20;
  localparam int HDR_VER_LSB = 16;
  localparam logic [15:0] CAP_ID = 16'h0010;

  // Status register bit positions
  localparam int ST_PRESENT = 0;
  localparam int ST_ALT_ROUTING_MISSING = 1;
  localparam int ST_COUNT_MISMATCH = 2;
  localparam int ST_BAR0_RESERVED = 3;
  localparam int ST_WRITE_REFUSED = 4;

  // First virtual function offset per layout mode
  localparam logic [15:0] FIRST_VF_OFFSET_PF0 = 16'h0040;
  localparam logic [15:0] FIRST_VF_OFFSET_PF1 = 16'h003F;

  // Page size bitmap bit n means 2^(n + PAGE_SHIFT_BASE) bytes
  localparam logic [5:0] PAGE_SHIFT_BASE = 6'h0C;

  // BAR0 type select encodings
  localparam logic [2:0] BAR_DISABLED = 3'h0;
  localparam logic [2:0] BAR_IO32 = 3'h1;
  localparam logic [2:0] BAR_MEM32_NP = 3'h4;
  localparam logic [2:0] BAR_MEM32_PF = 3'h5;
  localparam logic [2:0] BAR_MEM64_NP = 3'h6;
  localparam logic [2:0] BAR_MEM64_PF = 3'h7;

  // Reset value of read data
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic {
    LAYOUT_PF0_FIRST,
    LAYOUT_PF1_FIRST
  } layout_mode_t;

endpackage

// ### hw/sriov_capability_config.sv
// Virtualization extended capability register bank for function 0
//
// Contract
// [RL1] Capability present only when enabled, function 0
// [RL2] Integrator sets alternative routing feature too
// [RL3] Next pointer in header bits 31 to 20
// [RL4] Capability version in header bits 19 to 16
// [RL5] Report 16-bit initial virtual function count
// [RL6] Integrator makes total count equal initial
// [RL7] Report 16-bit function dependency link
// [RL8] Report 16-bit first virtual function offset
// [RL9] Default offset follows the layout mode
// [RL10] One device code for every virtual function
// [RL11] Report 32-bit supported page size bitmap
// [RL12] Decode BAR0 type codes for 32-bit kinds
// [RL13] Codes 110 and 111 span BAR0 and BAR1
// [RL14] All capability fields read-only after reset
module sriov_capability_config #(
  parameter bit virtualization_feature_on = 1'b1,
  parameter bit alt_routing_id_feature_on = 1'b1,
  parameter logic [11:0] next_capability_pointer = 12'h000,
  parameter logic [3:0] capability_version = 4'h1,
  parameter logic [15:0] initial_virtual_function_count = 16'h0006,
  parameter logic [15:0] total_virtual_function_count = 16'h0006,
  parameter logic [15:0] function_dependency_link = 16'h0000,
  parameter sriov_cap_pkg::layout_mode_t virtual_function_layout_mode =
    sriov_cap_pkg::LAYOUT_PF0_FIRST,
  parameter bit first_offset_override = 1'b0,
  parameter logic [15:0] first_virtual_function_offset = 16'h0040,
  parameter logic [15:0] virtual_function_device_code = 16'h1234,
  parameter logic [31:0] supported_page_size_bitmap = 32'h0000_0553,
  parameter logic [2:0] first_bar_type_select = 3'h4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [sriov_cap_pkg::ADDR_W-1:0] addr_i,
  input wire logic [2:0] func_sel_i,
  input wire logic [sriov_cap_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [sriov_cap_pkg::DATA_W-1:0] rdata_o,
  output logic cap_present_o,
  output logic config_invalid_o,
  output logic bar0_enabled_o,
  output logic bar0_is_io_o,
  output logic bar0_prefetch_o,
  output logic bar0_is_64_o,
  output logic bar1_upper_half_o,
  output logic bar0_reserved_o,
  output logic write_refused_o
);
  import sriov_cap_pkg::*;

  // Default offset of the first virtual function from the layout mode
  function automatic logic [15:0] default_offset(input layout_mode_t m);
    logic [15:0] r;
    r = FIRST_VF_OFFSET_PF0;
    case (m)
      LAYOUT_PF0_FIRST: r = FIRST_VF_OFFSET_PF0; // RL9
      LAYOUT_PF1_FIRST: r = FIRST_VF_OFFSET_PF1; // RL9
      default: r = FIRST_VF_OFFSET_PF0;
    endcase
    return r;
  endfunction

  // Address decode, used only by the write path through is_cap_field
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      OFF_HEADER,
      OFF_VF_COUNTS,
      OFF_OFFSET_DEP,
      OFF_VF_DEVICE,
      OFF_PAGE_SIZES,
      OFF_BAR0,
      OFF_STATUS,
      OFF_PAGE_INFO: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Fields that belong to the capability proper, not the status words
  function automatic logic is_cap_field(input logic [ADDR_W-1:0] a);
    return is_mapped(a) && (a != OFF_STATUS) && (a != OFF_PAGE_INFO);
  endfunction

  // Smallest supported page, as its shift; zero when none is set
  function automatic logic [5:0] min_page_shift(input logic [31:0] map);
    logic [5:0] s;
    s = 6'h00;
    for (int n = 31; n >= 0; n--) begin
      if (map[n]) begin
        s = PAGE_SHIFT_BASE + 6'(n); // RL11
      end
    end
    return s;
  endfunction

  localparam logic [15:0] OFFSET_VALUE = first_offset_override ?
    first_virtual_function_offset :
    default_offset(virtual_function_layout_mode);

  // Presence needs both features; the routing feature is an integrator duty
  localparam bit PRESENT_CFG = virtualization_feature_on &&
    alt_routing_id_feature_on; // RL1 RL2
  localparam bit ALT_MISSING_CFG = virtualization_feature_on &&
    !alt_routing_id_feature_on; // RL2
  localparam bit COUNT_MISMATCH_CFG =
    (total_virtual_function_count != initial_virtual_function_count); // RL6

  // Held fields, loaded by hard reset and never by a write
  logic present_reg;
  logic [11:0] next_ptr_reg;
  logic [3:0] version_reg;
  logic [15:0] initial_vf_reg;
  logic [15:0] total_vf_reg;
  logic [15:0] dep_link_reg;
  logic [15:0] first_offset_reg;
  logic [15:0] vf_device_reg;
  logic [31:0] page_map_reg;
  logic [2:0] bar_type_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      present_reg <= PRESENT_CFG; // RL1
      next_ptr_reg <= next_capability_pointer; // RL3
      version_reg <= capability_version; // RL4
      initial_vf_reg <= initial_virtual_function_count; // RL5
      total_vf_reg <= total_virtual_function_count;
      dep_link_reg <= function_dependency_link; // RL7
      first_offset_reg <= OFFSET_VALUE; // RL8
      vf_device_reg <= virtual_function_device_code; // RL10
      page_map_reg <= supported_page_size_bitmap; // RL11
      bar_type_reg <= first_bar_type_select;
    end else begin
      // Configuration writes leave every field as reset set it
      present_reg <= present_reg; // RL14
      next_ptr_reg <= next_ptr_reg;
      version_reg <= version_reg;
      initial_vf_reg <= initial_vf_reg;
      total_vf_reg <= total_vf_reg;
      dep_link_reg <= dep_link_reg;
      first_offset_reg <= first_offset_reg;
      vf_device_reg <= vf_device_reg;
      page_map_reg <= page_map_reg;
      bar_type_reg <= bar_type_reg;
    end
  end

  // BAR0 type decode
  logic bar_en_next;
  logic bar_io_next;
  logic bar_pf_next;
  logic bar_64_next;
  logic bar_rsv_next;
  logic [3:0] bar_low_next;

  always_comb begin
    bar_en_next = 1'b1;
    bar_io_next = 1'b0;
    bar_pf_next = 1'b0;
    bar_64_next = 1'b0;
    bar_rsv_next = 1'b0;
    bar_low_next = 4'h0;
    case (bar_type_reg)
      BAR_DISABLED: begin
        bar_en_next = 1'b0; // RL12
      end
      BAR_IO32: begin
        bar_io_next = 1'b1; // RL12
        bar_low_next = 4'h1;
      end
      BAR_MEM32_NP: begin
        bar_low_next = 4'h0; // RL12
      end
      BAR_MEM32_PF: begin
        bar_pf_next = 1'b1; // RL12
        bar_low_next = 4'h8;
      end
      BAR_MEM64_NP: begin
        bar_64_next = 1'b1; // RL13
        bar_low_next = 4'h4;
      end
      BAR_MEM64_PF: begin
        bar_64_next = 1'b1; // RL13
        bar_pf_next = 1'b1;
        bar_low_next = 4'hC;
      end
      default: begin
        // Reserved codes behave as a disabled BAR
        bar_en_next = 1'b0; // RL12
        bar_rsv_next = 1'b1;
      end
    endcase
  end

  logic bar_en_reg;
  logic bar_io_reg;
  logic bar_pf_reg;
  logic bar_64_reg;
  logic bar_rsv_reg;
  logic [3:0] bar_low_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bar_en_reg <= 1'b0;
      bar_io_reg <= 1'b0;
      bar_pf_reg <= 1'b0;
      bar_64_reg <= 1'b0;
      bar_rsv_reg <= 1'b0;
      bar_low_reg <= 4'h0;
    end else begin
      bar_en_reg <= bar_en_next && present_reg;
      bar_io_reg <= bar_io_next && present_reg;
      bar_pf_reg <= bar_pf_next && present_reg;
      bar_64_reg <= bar_64_next && present_reg; // RL13
      bar_rsv_reg <= bar_rsv_next;
      bar_low_reg <= bar_low_next;
    end
  end

  // Smallest supported page, kept for software that wants it ready-made
  logic [5:0] page_shift_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_shift_reg <= 6'h00;
    end else begin
      page_shift_reg <= min_page_shift(page_map_reg); // RL11
    end
  end

  // Only function 0 carries the capability
  logic fn0_hit;
  assign fn0_hit = (func_sel_i == 3'h0) && present_reg; // RL1

  // Sticky flag for a write aimed at a read-only capability field of function 0
  logic wr_refused_set;
  logic wr_refused_clr;
  logic wr_refused_reg;

  assign wr_refused_set = wr_i && fn0_hit && is_cap_field(addr_i); // RL14
  assign wr_refused_clr = wr_i && (func_sel_i == 3'h0) &&
    (addr_i == OFF_STATUS) && wdata_i[ST_WRITE_REFUSED];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_refused_reg <= 1'b0;
    end else if (wr_refused_set) begin
      // Set beats clear so a refused write is never lost
      wr_refused_reg <= 1'b1;
    end else if (wr_refused_clr) begin
      wr_refused_reg <= 1'b0;
    end
  end

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_PRESENT] = present_reg;
    status_word[ST_ALT_ROUTING_MISSING] = ALT_MISSING_CFG; // RL2
    status_word[ST_COUNT_MISMATCH] = COUNT_MISMATCH_CFG; // RL6
    status_word[ST_BAR0_RESERVED] = bar_rsv_reg;
    status_word[ST_WRITE_REFUSED] = wr_refused_reg;
  end

  // Read mux
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = RDATA_RESET;
    if (rd_i && (func_sel_i == 3'h0)) begin
      case (addr_i)
        OFF_HEADER: begin
          if (present_reg) begin
            rdata_next[31:HDR_NEXT_LSB] = next_ptr_reg; // RL3
            rdata_next[19:HDR_VER_LSB] = version_reg; // RL4
            rdata_next[15:0] = CAP_ID;
          end
        end
        OFF_VF_COUNTS: begin
          if (present_reg) begin
            rdata_next[15:0] = initial_vf_reg; // RL5
            rdata_next[31:16] = total_vf_reg;
          end
        end
        OFF_OFFSET_DEP: begin
          if (present_reg) begin
            rdata_next[15:0] = first_offset_reg; // RL8
            rdata_next[31:16] = dep_link_reg; // RL7
          end
        end
        OFF_VF_DEVICE: begin
          if (present_reg) begin
            rdata_next[31:16] = vf_device_reg; // RL10
          end
        end
        OFF_PAGE_SIZES: begin
          if (present_reg) begin
            rdata_next = page_map_reg; // RL11
          end
        end
        OFF_BAR0: begin
          if (present_reg) begin
            rdata_next[3:0] = bar_low_reg; // RL12 RL13
          end
        end
        OFF_STATUS: begin
          rdata_next = status_word;
        end
        OFF_PAGE_INFO: begin
          if (present_reg) begin
            rdata_next[5:0] = page_shift_reg;
          end
        end
        default: begin
          rdata_next = RDATA_RESET;
        end
      endcase
    end
  end

  // Read data stand for one cycle only, then fall back to zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= RDATA_RESET;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  // Level outputs straight from flip-flops
  logic invalid_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      invalid_reg <= 1'b0;
    end else begin
      invalid_reg <= ALT_MISSING_CFG || COUNT_MISMATCH_CFG; // RL2 RL6
    end
  end

  assign cap_present_o = present_reg;
  assign config_invalid_o = invalid_reg;
  assign bar0_enabled_o = bar_en_reg;
  assign bar0_is_io_o = bar_io_reg;
  assign bar0_prefetch_o = bar_pf_reg;
  assign bar0_is_64_o = bar_64_reg;
  // The upper half of a 64-bit BAR0 takes BAR1 away from its own use
  assign bar1_upper_half_o = bar_64_reg; // RL13
  assign bar0_reserved_o = bar_rsv_reg;
  assign write_refused_o = wr_refused_reg;

endmodule
